// *** wdt_map.svh ***
// Purpose: constants for the watchdog timer block
// Assumes: APB byte addresses equal register offsets (all multiples of four)
// Notes:   included by the divider, APB slave and top design files
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

`define WDT_OFF_IRQ_EN      12'h0a8
`define WDT_OFF_CONTROL     12'h0d8
`define WDT_OFF_EXT_EN      12'h0e8
`define WDT_OFF_EXT_PRIO    12'h0f8
`define WDT_OFF_CLK_CFG     12'h08c

`define WDT_RST_BYTE        8'h00

`define WDT_BIT_GATE        7
`define WDT_BIT_TIMEOUT_EN  4
`define WDT_BIT_TIMEOUT_PRI 4
`define WDT_BIT_RESTART     0
`define WDT_BIT_RST_EN      1
`define WDT_BIT_RST_FLAG    2
`define WDT_BIT_IRQ_FLAG    3
`define WDT_SEL_HI          7
`define WDT_SEL_LO          6

`define WDT_PRE_RESET_CYC   10'd512
`define WDT_CORE_RST_CYC    4'd8

`define WDT_TAP0            5'd16
`define WDT_TAP1            5'd19
`define WDT_TAP2            5'd22
`define WDT_TAP3            5'd25

`endif

// *** wdt_pkg.sv ***
// Purpose: shared types of the watchdog timer block
// Assumes: nothing
// Notes:   constants live in wdt_map.svh
package wdt_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } wdt_apb_req_type;

    typedef struct packed {
        logic        timeout;
        logic        pre_reset;
    } wdt_event_type;

    typedef enum logic [1:0] {
        WDT_RUN,
        WDT_GRACE,
        WDT_RESET
    } wdt_state_type;

endpackage

// *** wdt_divider.sv ***
// Purpose: free-running prescaler for the watchdog
// Assumes: single clock, synchronous active-low reset
// Notes:   restart clears the chain so intervals start clean
`include "wdt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module wdt_divider (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        restart_i,
    input  wire logic [1:0]  interval_select_i,
    output logic             expire_o
);
    logic [25:0] chain_q;
    logic [4:0]  tap;
    logic [26:0] next_count;

    assign tap        = (interval_select_i == 2'd0) ? `WDT_TAP0 :
                        (interval_select_i == 2'd1) ? `WDT_TAP1 :
                        (interval_select_i == 2'd2) ? `WDT_TAP2 : `WDT_TAP3;
    assign next_count = {1'b0, chain_q} + 27'd1;
    // Interval ends when the selected tap bit first becomes set
    assign expire_o   = next_count[tap] && !chain_q[tap];

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || restart_i || expire_o) begin
            chain_q <= 26'h0;
        end else begin
            chain_q <= next_count[25:0];
        end
    end
endmodule
`default_nettype wire

// *** wdt_apb_slave.sv ***
// Purpose: APB slave front end, zero-wait access
// Assumes: APB3 signalling from one master
// Notes:   produces a one-cycle write strobe
`include "wdt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module wdt_apb_slave (
    input  wire logic                     ref_clk_i,
    input  wire logic                     rst_n_i,
    input  wire wdt_pkg::wdt_apb_req_type req_i,
    input  wire logic [7:0]               rdata_i,
    input  wire logic                     hit_i,
    output logic                          wr_stb_o,
    output logic                          pready_o,
    output logic                          pslverr_o,
    output logic [31:0]                   prdata_o
);
    logic access;

    assign access   = req_i.psel && !req_i.penable;
    assign wr_stb_o = req_i.psel && req_i.penable && req_i.pwrite && pready_o;

    // Registered answer: data captured in setup, ready in access phase
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
        end else begin
            pready_o  <= access;
            pslverr_o <= access && !hit_i;
            if (access && !req_i.pwrite) begin
                prdata_o <= {24'h0, rdata_i};
            end else if (!access) begin
                prdata_o <= 32'h0;
            end
        end
    end
endmodule
`default_nettype wire

// *** wdt_top.sv ***
// Purpose: watchdog timer with interrupt and reset functions
// Assumes: APB registers; timed-access unlock done outside
// Notes:   interrupt priority is exported, not arbitrated here
`include "wdt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module wdt_top (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic        access_permit_i,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic [31:0]      prdata_o,
    output logic             timeout_irq_o,
    output logic             timeout_irq_priority_o,
    output logic             core_reset_o
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] interrupt_enable_q;
    logic [7:0] extended_irq_enable_q;
    logic [7:0] extended_irq_priority_q;
    logic [7:0] clock_config_reg_q;
    logic       timeout_irq_flag_q;
    logic       timeout_reset_flag_q;
    logic       timeout_reset_enable_q;
    logic       restart_request_q;
    logic [9:0] grace_q;
    logic [3:0] hold_q;
    wdt_pkg::wdt_state_type state_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wdt_pkg::wdt_apb_req_type req;
    logic       wr_stb;
    logic [7:0] wbyte;
    logic       hit_gen;
    logic       hit_ctl;
    logic       hit_een;
    logic       hit_epr;
    logic       hit_ckc;
    logic       hit;
    logic [7:0] control_view;
    logic [7:0] rdata;
    logic       wr_ctl;
    logic       wr_ctl_prot;

    assign req     = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i,
                       paddr: paddr_i, pwdata: pwdata_i};
    assign wbyte   = pwdata_i[7:0];
    assign hit_gen = (paddr_i == `WDT_OFF_IRQ_EN);
    assign hit_ctl = (paddr_i == `WDT_OFF_CONTROL);
    assign hit_een = (paddr_i == `WDT_OFF_EXT_EN);
    assign hit_epr = (paddr_i == `WDT_OFF_EXT_PRIO);
    assign hit_ckc = (paddr_i == `WDT_OFF_CLK_CFG);
    assign hit     = hit_gen || hit_ctl || hit_een || hit_epr || hit_ckc;
    assign wr_ctl      = wr_stb && hit_ctl;
    assign wr_ctl_prot = wr_ctl && access_permit_i;

    assign control_view = {4'h0, timeout_irq_flag_q, timeout_reset_flag_q,
                           timeout_reset_enable_q, restart_request_q};

    always_comb begin
        if (hit_gen) begin
            rdata = interrupt_enable_q;
        end else if (hit_ctl) begin
            rdata = control_view;
        end else if (hit_een) begin
            rdata = extended_irq_enable_q;
        end else if (hit_epr) begin
            rdata = extended_irq_priority_q;
        end else if (hit_ckc) begin
            rdata = clock_config_reg_q;
        end else begin
            rdata = 8'h00;
        end
    end

    wdt_apb_slave u_apb (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .req_i     (req),
        .rdata_i   (rdata),
        .hit_i     (hit),
        .wr_stb_o  (wr_stb),
        .pready_o  (pready_o),
        .pslverr_o (pslverr_o),
        .prdata_o  (prdata_o)
    );

    // ------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------
    logic expire;
    logic restart_cnt;
    logic grace_done;
    logic hw_timeout;
    logic fire_reset;

    // Restart bit and the reset recovery both restart the interval
    assign restart_cnt = restart_request_q || (state_q == wdt_pkg::WDT_RESET);

    wdt_divider u_div (
        .ref_clk_i         (ref_clk_i),
        .rst_n_i           (rst_n_i),
        .restart_i         (restart_cnt),
        .interval_select_i (clock_config_reg_q[`WDT_SEL_HI:`WDT_SEL_LO]),
        .expire_o          (expire)
    );

    assign hw_timeout = expire && (state_q == wdt_pkg::WDT_RUN);
    assign grace_done = (state_q == wdt_pkg::WDT_GRACE) &&
                        (grace_q == `WDT_PRE_RESET_CYC - 10'd1);
    // Reset only when enabled; interrupt path is untouched by this
    assign fire_reset = grace_done && timeout_reset_enable_q;

    // ------------------------------------------------------------
    // Timeout sequencing
    // ------------------------------------------------------------
    // Flag comes first, reset follows after the grace window
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_q <= wdt_pkg::WDT_RUN;
            grace_q <= 10'h0;
            hold_q  <= 4'h0;
        end else begin
            case (state_q)
                wdt_pkg::WDT_RUN: begin
                    grace_q <= 10'h0;
                    if (hw_timeout) begin
                        state_q <= wdt_pkg::WDT_GRACE;
                    end
                end
                wdt_pkg::WDT_GRACE: begin
                    grace_q <= grace_q + 10'd1;
                    if (restart_request_q) begin
                        state_q <= wdt_pkg::WDT_RUN;
                    end else if (fire_reset) begin
                        state_q <= wdt_pkg::WDT_RESET;
                        hold_q  <= `WDT_CORE_RST_CYC;
                    end else if (grace_done) begin
                        state_q <= wdt_pkg::WDT_RUN;
                    end
                end
                wdt_pkg::WDT_RESET: begin
                    hold_q <= hold_q - 4'd1;
                    if (hold_q == 4'd1) begin
                        state_q <= wdt_pkg::WDT_RUN;
                    end
                end
                default: begin
                    state_q <= wdt_pkg::WDT_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic flag_set;
    logic flag_clr;
    logic rflag_set;

    // Software write of one sets the flag just as a timeout does
    assign flag_set  = hw_timeout ||
                       (wr_ctl_prot && wbyte[`WDT_BIT_IRQ_FLAG]);
    assign flag_clr  = wr_ctl_prot && !wbyte[`WDT_BIT_IRQ_FLAG];
    // Software set of the reset flag does not trigger a reset
    assign rflag_set = fire_reset ||
                       (wr_ctl_prot && wbyte[`WDT_BIT_RST_FLAG]);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            timeout_irq_flag_q     <= 1'b0;
            timeout_reset_flag_q   <= 1'b0;
            timeout_reset_enable_q <= 1'b0;
            restart_request_q      <= 1'b0;
        end else begin
            // Set wins over a clear in the same cycle
            if (flag_set) begin
                timeout_irq_flag_q <= 1'b1;
            end else if (flag_clr) begin
                timeout_irq_flag_q <= 1'b0;
            end
            if (rflag_set) begin
                timeout_reset_flag_q <= 1'b1;
            end else if (wr_ctl_prot) begin
                timeout_reset_flag_q <= 1'b0;
            end
            if (wr_ctl_prot) begin
                timeout_reset_enable_q <= wbyte[`WDT_BIT_RST_EN];
            end
            // One-shot: held one cycle, then cleared by hardware
            restart_request_q <= wr_ctl_prot && wbyte[`WDT_BIT_RESTART];
        end
    end

    // ------------------------------------------------------------
    // Plain enable, priority and clock config registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            interrupt_enable_q      <= `WDT_RST_BYTE;
            extended_irq_enable_q   <= `WDT_RST_BYTE;
            extended_irq_priority_q <= `WDT_RST_BYTE;
            clock_config_reg_q      <= `WDT_RST_BYTE;
        end else if (wr_stb) begin
            if (hit_gen) begin
                interrupt_enable_q <= wbyte;
            end else if (hit_een) begin
                extended_irq_enable_q <= {3'h0, wbyte[4:0]};
            end else if (hit_epr) begin
                extended_irq_priority_q <= {3'h0, wbyte[4:0]};
            end else if (hit_ckc) begin
                clock_config_reg_q <= wbyte;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            timeout_irq_o          <= 1'b0;
            timeout_irq_priority_o <= 1'b0;
            core_reset_o           <= 1'b0;
        end else begin
            // Stays raised until software clears the flag, the gate bit or the timeout enable bit
            timeout_irq_o <= timeout_irq_flag_q &&
                             extended_irq_enable_q[`WDT_BIT_TIMEOUT_EN] &&
                             interrupt_enable_q[`WDT_BIT_GATE];
            timeout_irq_priority_o <= extended_irq_priority_q[`WDT_BIT_TIMEOUT_PRI];
            core_reset_o <= (state_q == wdt_pkg::WDT_RESET);
        end
    end
endmodule
`default_nettype wire

// *** wdt_top_props.sv ***
// Purpose: port-level checks for the watchdog block
// Assumes: zero-wait APB slave, registered outputs
// Notes:   helper copies of enable and priority bits follow committed writes
`timescale 1ns/1ps
`default_nettype none
module wdt_top_props (
    input wire logic        ref_clk_i,
    input wire logic        rst_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        access_permit_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [31:0] prdata_o,
    input wire logic        timeout_irq_o,
    input wire logic        timeout_irq_priority_o,
    input wire logic        core_reset_o
);
    logic gate_q;
    logic en_q;
    logic pri_q;
    wire logic wr_w  = psel_i && penable_i && pready_o && pwrite_i;
    wire logic map_w = paddr_i == 12'h0a8 || paddr_i == 12'h0d8 || paddr_i == 12'h0e8
                    || paddr_i == 12'h0f8 || paddr_i == 12'h08c;
    wire logic ok_w  = gate_q && en_q;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            gate_q <= 1'b0;
            en_q   <= 1'b0;
            pri_q  <= 1'b0;
        end else begin
            if (wr_w && paddr_i == 12'h0a8) gate_q <= pwdata_i[7];
            if (wr_w && paddr_i == 12'h0e8) en_q <= pwdata_i[4];
            if (wr_w && paddr_i == 12'h0f8) pri_q <= pwdata_i[4];
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_access;
        psel_i && penable_i;
    endsequence

    a_ready_access: assert property (s_setup ##1 s_access |-> pready_o)
        else $error("ready missing in access cycle");
    a_ready_only: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside access cycle");
    a_err_decode: assert property (pready_o |-> pslverr_o == !map_w)
        else $error("error flag does not match address map");
    a_rdata_upper: assert property (pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_reset_len: assert property ($rose(core_reset_o) |-> core_reset_o[*8] ##1 !core_reset_o)
        else $error("core reset length wrong");
    a_reset_spacing: assert property ($fell(core_reset_o) |-> !core_reset_o[*8])
        else $error("core reset repeated at once");
    a_prio_follow: assert property (wr_w && paddr_i == 12'h0f8 |=> ##1 timeout_irq_priority_o == pri_q)
        else $error("priority output does not follow register");
    a_irq_gated: assert property (timeout_irq_o |-> ok_w || $past(ok_w))
        else $error("interrupt raised while gated off");
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench for the watchdog block
// Assumes: zero-wait APB, tap 16 for interval code 0
// Notes:   one real timeout only, to keep the run short
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        ref_clk_i, rst_n_i, psel_i, penable_i, pwrite_i, access_permit_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic        pready_o, pslverr_o, timeout_irq_o, timeout_irq_priority_o, core_reset_o, er;
    logic [7:0]  d;
    integer      seed, mismatches, comparisons, i, n, cyc, t0, t1, t2;
    logic [11:0] regs [4] = '{12'h0a8, 12'h0e8, 12'h0f8, 12'h08c};

    wdt_top dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .access_permit_i(access_permit_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .prdata_o(prdata_o), .timeout_irq_o(timeout_irq_o),
        .timeout_irq_priority_o(timeout_irq_priority_o), .core_reset_o(core_reset_o));

    always #50 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) cyc <= cyc + 1;

    // Readable bits differ per register; clock config checked on the select field only
    function automatic logic [31:0] mask_of(input integer k);
        return (k == 0) ? 32'hff : (k == 3) ? 32'hc0 : 32'h1f;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Lets one edge pass first so psel never gets two assignments in one step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= a;
        pwdata_i <= {24'h0, v};
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        if (n >= 16) begin
            mismatches++;
            summarize();
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wait_sig(input integer sel);
        n = 0;
        while ((sel == 0 ? timeout_irq_o : sel == 1 ? core_reset_o : !core_reset_o) !== 1'b1
               && n < 70000) begin
            @(posedge ref_clk_i);
            n++;
        end
        if (n >= 70000) begin
            mismatches++;
            summarize();
        end
    endtask

    initial begin
        ref_clk_i = 1'b0; rst_n_i = 1'b0; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
        paddr_i = 12'h0; pwdata_i = 32'h0; access_permit_i = 1'b0;
        seed = 32'h84ce3403; mismatches = 0; comparisons = 0; cyc = 0;
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 4; i++) begin
            apb(1'b0, regs[i], 8'h0);
            chk(rd, 32'h0);
        end
        apb(1'b0, 12'h0d8, 8'h0);
        chk(rd, 32'h0);
        for (i = 0; i < 16; i++) begin
            d = 8'($random(seed));
            apb(1'b1, regs[i % 4], d);
            apb(1'b0, regs[i % 4], 8'h0);
            chk(rd & mask_of(i % 4), {24'h0, d} & mask_of(i % 4));
            repeat (2) @(posedge ref_clk_i);
            if (i % 4 == 2) chk(timeout_irq_priority_o, d[4]);
        end
        access_permit_i <= 1'b1;
        for (i = 0; i < 8; i++) begin
            apb(1'b1, 12'h0a8, {i[0], 7'h0});
            apb(1'b1, 12'h0e8, {3'h0, i[1], 4'h0});
            apb(1'b1, 12'h0d8, {4'h0, i[2], 3'h0});
            repeat (3) @(posedge ref_clk_i);
            chk(timeout_irq_o, &i[2:0]);
        end
        @(posedge ref_clk_i);
        access_permit_i <= 1'b0;
        apb(1'b1, 12'h0d8, 8'h02);
        apb(1'b0, 12'h0d8, 8'h0);
        chk(rd, 32'h08);
        chk(timeout_irq_o, 1'b1);
        @(posedge ref_clk_i);
        access_permit_i <= 1'b1;
        apb(1'b1, 12'h0d8, 8'h01);
        apb(1'b0, 12'h0d8, 8'h0);
        chk(rd, 32'h0);
        repeat (2) @(posedge ref_clk_i);
        chk(timeout_irq_o, 1'b0);
        apb(1'b0, 12'h0a4, 8'h0);
        chk({er, rd}, {1'b1, 32'h0});
        apb(1'b1, 12'h0ac, 8'h00);
        apb(1'b0, 12'h0a8, 8'h0);
        chk(rd, 32'h80);
        // Wait before restarting so a missed restart shows as an early timeout
        apb(1'b1, 12'h08c, 8'h00);
        repeat (2000) @(posedge ref_clk_i);
        apb(1'b1, 12'h0d8, 8'h01);
        t0 = cyc;
        apb(1'b1, 12'h0d8, 8'h02);
        wait_sig(0);
        t1 = cyc;
        chk(32'((t1 - t0) >= 65532 && (t1 - t0) <= 65540), 32'h1);
        wait_sig(1);
        t2 = cyc;
        chk(32'((t2 - t1) >= 509 && (t2 - t1) <= 515), 32'h1);
        wait_sig(2);
        apb(1'b0, 12'h0d8, 8'h0);
        chk(rd, 32'h0e);
        chk(timeout_irq_o, 1'b1);
        apb(1'b1, 12'h0d8, 8'h08);
        apb(1'b0, 12'h0d8, 8'h0);
        chk(rd, 32'h08);
        summarize();
    end
endmodule

bind wdt_top wdt_top_props chk_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .access_permit_i(access_permit_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .prdata_o(prdata_o), .timeout_irq_o(timeout_irq_o),
    .timeout_irq_priority_o(timeout_irq_priority_o), .core_reset_o(core_reset_o));
`default_nettype wire
